// ### inc/sicp_defs.svh
`ifndef SICP_DEFS_SVH
`define SICP_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SICP_IDX_PWR 10'h001
`define SICP_IDX_CFG 10'h004
`define SICP_IDX_STAT 10'h00c
`define SICP_IDX_AUD 10'h012
`define SICP_IDX_INTCTL 10'h0c6
`define SICP_IDX_ISR 10'h0c7

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SICP_PWR_RPD_EN 7
`define SICP_PWR_SLEEP_EN 6
`define SICP_CFG_LF_HI 1
`define SICP_CFG_LF_LO 0
`define SICP_CFG_FILT_EN 2
`define SICP_CFG_EDGE_SEL 3
`define SICP_CFG_REPEATER 4
`define SICP_CFG_BACKCOMP 5
`define SICP_AUD_CHB 0
`define SICP_AUD_C18 2
`define SICP_INT_FWD_A 5
`define SICP_INT_FWD_B 0
`define SICP_STAT_LINK 0
`define SICP_STAT_PCLK 1
`define SICP_STAT_SLEEP 2
`define SICP_STAT_RPD 3
`define SICP_ISR_PEND 0
`define SICP_ISR_LEVEL 1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SICP_PWR_RST 8'h00
`define SICP_CFG_RST 8'h0c
`define SICP_AUD_RST 8'h00
`define SICP_INTCTL_RST 8'h00

// ----------------------------------------------------------------------------
// timing and data shaping
// ----------------------------------------------------------------------------
`define SICP_CLK_MHZ 250
`define SICP_PCLK_LOSS_NS 1000
`define SICP_PCLK_LOSS_CYC ((`SICP_PCLK_LOSS_NS * `SICP_CLK_MHZ) / 1000)
`define SICP_WIN_PCLK 130
`define SICP_MIN_PULSE 3
`define SICP_STRAP_MODES 10
`define SICP_COLOR18_MASK 24'hfcfcfc

`endif

// ### inc/sicp_pkg.sv
package sicp_pkg;

    // link power state
    typedef enum logic [1:0] {
        SICP_ST_PDOWN,
        SICP_ST_ACTIVE,
        SICP_ST_REMOTE_PD,
        SICP_ST_SLEEP
    } sicp_state_t;

    // settings carried by the strap level
    typedef struct packed {
        logic low_freq;
        logic repeater;
        logic backcomp;
        logic audio_b;
    } sicp_strap_t;

endpackage

// ### hdl/sicp_ctrl.sv
// Notes on behaviour
// - filter on: 2 edges/130, drop under 3
// - filter off: 2 edges/130, any width
// - frame_sync: one edge per 130
// - powerdown_n low disables link
// - remote power-down: reduced power, auto-return
// - pixel clock loss: sleep, relock on return
// - registers kept through clock loss, sleep
// - link fault reads zero at status bit0
// - edge select: one rising, zero falling
// - low_freq_range from register or strap
// - remote interrupt low drives pin low
// - status read clears pending, releases pin
// - new interrupt only on next falling edge
// - configuration from register or strap pin
// - strap level decodes to four settings
// - repeater off by default
// - backward-compatible off by default
// - audio channel b: 18-bit colour input
// - audio channel b also set by register
`timescale 1ns/1ps
`default_nettype none
`include "sicp_defs.svh"

module sicp_ctrl
    import sicp_pkg::*;
(
    // system clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // parallel video input pins
    input wire logic pclk_in,
    input wire logic [23:0] pixel_data_in,
    input wire logic video_active_flag,
    input wire logic line_sync,
    input wire logic frame_sync,
    input wire logic secondary_audio_data,
    // power, strap and link status pins
    input wire logic powerdown_n,
    input wire logic [3:0] config_strap_level,
    input wire logic link_detect,
    input wire logic remote_powered_down,
    input wire logic remote_interrupt_in,
    // towards the serial encoder
    output logic [23:0] link_pixel_data,
    output logic link_pixel_stb,
    output logic link_active_flag,
    output logic link_line_sync,
    output logic link_frame_sync,
    output logic link_audio_data,
    output logic link_enable,
    output logic link_sleep,
    output logic link_reduced_power,
    // mode outputs
    output logic low_freq_range,
    output logic repeater_mode,
    output logic legacy_format,
    output logic audio_b_mode,
    output logic color18_mode,
    // interrupt pin
    output logic interrupt_out_n
);

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    localparam int SW = 37;
    logic [SW-1:0] sync1_q;
    logic [SW-1:0] sync2_q;
    wire [SW-1:0] pins_raw = {pclk_in, powerdown_n, link_detect, remote_powered_down,
                              remote_interrupt_in, frame_sync, line_sync,
                              video_active_flag, secondary_audio_data, pixel_data_in,
                              config_strap_level};

    // every pin comes from outside this clock, so all go through two stages
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    wire pclk_s = sync2_q[36];
    wire pdn_s = sync2_q[35];
    wire link_ok_s = sync2_q[34];
    wire rpd_s = sync2_q[33];
    wire rint_s = sync2_q[32];
    wire [2:0] ctl_s = sync2_q[31:29];
    wire aud_s = sync2_q[28];
    wire [23:0] din_s = sync2_q[27:4];
    wire [3:0] strap_s = sync2_q[3:0];

    // ------------------------------------------------------------------------
    // pixel clock edges and loss detection
    // ------------------------------------------------------------------------
    logic pclk_d_q;
    logic rint_d_q;
    logic [8:0] loss_cnt_q;
    logic pclk_lost_q;
    wire pclk_rise = pclk_s & ~pclk_d_q;
    wire pclk_fall = ~pclk_s & pclk_d_q;
    wire rint_fall = rint_d_q & ~rint_s;

    // clock is called lost after about 1 us without a rising edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pclk_d_q <= 1'b0;
            rint_d_q <= 1'b0; // same as the synchroniser, so no false fall
            loss_cnt_q <= '0;
            pclk_lost_q <= 1'b1;
        end else begin
            pclk_d_q <= pclk_s;
            rint_d_q <= rint_s;
            if (pclk_rise) begin
                loss_cnt_q <= '0;
                pclk_lost_q <= 1'b0;
            end else if (loss_cnt_q == 9'(`SICP_PCLK_LOSS_CYC - 1)) begin
                pclk_lost_q <= 1'b1;
            end else begin
                loss_cnt_q <= loss_cnt_q + 9'd1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    // registers only see rst_n, so clock loss and sleep leave them intact
    logic [7:0] pwr_q;
    logic [7:0] cfg_q;
    logic [7:0] aud_q;
    logic [7:0] intctl_q;
    logic int_pend_q;
    sicp_state_t state_q;
    sicp_strap_t strap_q;

    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        hit = (a[11:2] == idx);
    endfunction

    wire hit_pwr = hit(paddr, `SICP_IDX_PWR);
    wire hit_cfg = hit(paddr, `SICP_IDX_CFG);
    wire hit_stat = hit(paddr, `SICP_IDX_STAT);
    wire hit_aud = hit(paddr, `SICP_IDX_AUD);
    wire hit_intctl = hit(paddr, `SICP_IDX_INTCTL);
    wire hit_isr = hit(paddr, `SICP_IDX_ISR);
    wire hit_any = hit_pwr | hit_cfg | hit_stat | hit_aud | hit_intctl | hit_isr;
    wire setup_ph = psel & ~penable;
    wire access_done = psel & penable & pready;
    wire wr_en = access_done & pwrite & ~pslverr;
    wire isr_read = access_done & ~pwrite & hit_isr;

    // status: link bit is zero under any cable fault
    wire [7:0] stat_val = {4'h0,
                           state_q == SICP_ST_REMOTE_PD,
                           state_q == SICP_ST_SLEEP,
                           ~pclk_lost_q,
                           link_ok_s};
    wire [7:0] isr_val = {6'h00, ~rint_s, int_pend_q};

    // read mux, registered in the setup cycle
    wire [7:0] rd_mux = hit_pwr ? pwr_q :
                        hit_cfg ? cfg_q :
                        hit_stat ? stat_val :
                        hit_aud ? aud_q :
                        hit_intctl ? intctl_q :
                        hit_isr ? isr_val : 8'h00;

    // one wait-free access phase: pready rises the cycle after setup
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~hit_any;
            if (setup_ph) begin
                prdata <= {24'h000000, rd_mux};
            end
        end
    end

    // writable registers; intctl keeps only the two forwarding bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= `SICP_PWR_RST;
            cfg_q <= `SICP_CFG_RST;
            aud_q <= `SICP_AUD_RST;
            intctl_q <= `SICP_INTCTL_RST;
        end else if (wr_en) begin
            if (hit_pwr) pwr_q <= pwdata[7:0] & 8'hc0;
            if (hit_cfg) cfg_q <= pwdata[7:0] & 8'h3f;
            if (hit_aud) aud_q <= pwdata[7:0] & 8'h05;
            if (hit_intctl) intctl_q <= pwdata[7:0] & 8'h21;
        end
    end

    // ------------------------------------------------------------------------
    // interrupt forwarding
    // ------------------------------------------------------------------------
    // both enable bits must be written by the controller first
    wire int_fwd_en = intctl_q[`SICP_INT_FWD_A] & intctl_q[`SICP_INT_FWD_B];
    // only a fresh falling edge raises it; a held low level does not re-arm
    wire int_set = int_fwd_en & rint_fall;
    wire int_pend_d = int_set | (int_pend_q & ~isr_read);

    // set wins over the clearing read in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_pend_q <= 1'b0;
            interrupt_out_n <= 1'b1;
        end else begin
            int_pend_q <= int_pend_d;
            interrupt_out_n <= ~int_pend_d;
        end
    end

    // ------------------------------------------------------------------------
    // strap decode and power state
    // ------------------------------------------------------------------------
    // strap level index 0..9, one per resistor ratio; others read as index 0
    function automatic sicp_strap_t strap_decode(input logic [3:0] lvl);
        unique case (lvl)
            4'h1: strap_decode = '{1'b0, 1'b0, 1'b0, 1'b1};
            4'h2: strap_decode = '{1'b0, 1'b1, 1'b0, 1'b0};
            4'h3: strap_decode = '{1'b0, 1'b1, 1'b0, 1'b1};
            4'h4: strap_decode = '{1'b1, 1'b0, 1'b0, 1'b0};
            4'h5: strap_decode = '{1'b1, 1'b0, 1'b0, 1'b1};
            4'h6: strap_decode = '{1'b1, 1'b1, 1'b0, 1'b0};
            4'h7: strap_decode = '{1'b1, 1'b1, 1'b0, 1'b1};
            4'h8: strap_decode = '{1'b0, 1'b0, 1'b1, 1'b0};
            4'h9: strap_decode = '{1'b1, 1'b0, 1'b1, 1'b0};
            default: strap_decode = '{1'b0, 1'b0, 1'b0, 1'b0};
        endcase
    endfunction

    wire rpd_en = pwr_q[`SICP_PWR_RPD_EN];
    wire sleep_en = pwr_q[`SICP_PWR_SLEEP_EN];
    wire lf_reg = |cfg_q[`SICP_CFG_LF_HI:`SICP_CFG_LF_LO];
    wire release_pd = (state_q == SICP_ST_PDOWN) & pdn_s;
    sicp_state_t state_d;
    wire sicp_strap_t strap_dec = strap_decode(strap_s);

    // next power state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SICP_ST_PDOWN: begin
                if (pdn_s) state_d = SICP_ST_ACTIVE;
            end
            SICP_ST_ACTIVE: begin
                if (sleep_en && pclk_lost_q) state_d = SICP_ST_SLEEP;
                else if (rpd_en && rpd_s) state_d = SICP_ST_REMOTE_PD;
            end
            SICP_ST_REMOTE_PD: begin
                if (!rpd_en || !rpd_s) state_d = SICP_ST_ACTIVE;
            end
            SICP_ST_SLEEP: begin
                if (!sleep_en || !pclk_lost_q) state_d = SICP_ST_ACTIVE;
            end
        endcase
        if (!pdn_s) state_d = SICP_ST_PDOWN;
    end

    // strap and range are caught only as power-down is released
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SICP_ST_PDOWN;
            strap_q <= '0;
            low_freq_range <= 1'b0;
        end else begin
            state_q <= state_d;
            if (release_pd) begin
                strap_q <= strap_dec;
                low_freq_range <= strap_dec.low_freq | lf_reg;
            end
        end
    end

    // register bit or strap may select each setting
    wire rep_eff = strap_q.repeater | cfg_q[`SICP_CFG_REPEATER];
    wire bc_eff = strap_q.backcomp | cfg_q[`SICP_CFG_BACKCOMP];
    wire audb_eff = strap_q.audio_b | aud_q[`SICP_AUD_CHB];
    wire c18_eff = audb_eff | aud_q[`SICP_AUD_C18];
    // no capture on the cycle that leaves active, so a strobe never outlives enable
    wire active = (state_q == SICP_ST_ACTIVE) & (state_d == SICP_ST_ACTIVE);

    // ------------------------------------------------------------------------
    // pixel capture
    // ------------------------------------------------------------------------
    wire edge_sel = cfg_q[`SICP_CFG_EDGE_SEL];
    wire tick = active & (edge_sel ? pclk_rise : pclk_fall);
    wire filt_en = cfg_q[`SICP_CFG_FILT_EN];
    wire [23:0] pix_masked = c18_eff ? (din_s & `SICP_COLOR18_MASK) : din_s;
    // capture on the selected pixel edge; audio input gated by channel b
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_pixel_data <= '0;
            link_pixel_stb <= 1'b0;
            link_audio_data <= 1'b0;
        end else begin
            link_pixel_stb <= tick;
            if (tick) begin
                link_pixel_data <= pix_masked;
                link_audio_data <= audb_eff & aud_s;
            end
        end
    end

    // ------------------------------------------------------------------------
    // control signal filter: 0 active flag, 1 line sync, 2 frame sync
    // ------------------------------------------------------------------------
    logic [2:0] ctl_out;
    genvar g;
    for (g = 0; g < 3; g++) begin : g_filt
        logic [1:0] run_q;
        logic [7:0] age_last_q;
        logic [7:0] age_prev_q;
        logic out_q;
        wire differs = ctl_s[g] ^ out_q;
        // frame sync is never shortened by the filter but needs 130 between edges
        wire [1:0] need_m1 = (filt_en && g < 2) ? 2'(`SICP_MIN_PULSE - 1) : 2'd0;
        wire [7:0] gate_age = (g == 2) ? age_last_q : age_prev_q;
        wire room = gate_age >= 8'(`SICP_WIN_PCLK - 1);
        wire fwd = tick & differs & (run_q >= need_m1) & room;

        // ages saturate so an idle signal passes its first edges at once
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                run_q <= '0;
                age_last_q <= 8'hff;
                age_prev_q <= 8'hff;
                out_q <= 1'b0;
            end else if (tick) begin
                if (fwd) begin
                    out_q <= ctl_s[g];
                    run_q <= '0;
                    age_prev_q <= age_last_q;
                    age_last_q <= '0;
                end else begin
                    run_q <= !differs ? 2'd0 : (run_q == 2'd3 ? run_q : run_q + 2'd1);
                    if (age_last_q != 8'hff) age_last_q <= age_last_q + 8'd1;
                    if (age_prev_q != 8'hff) age_prev_q <= age_prev_q + 8'd1;
                end
            end
        end
        assign ctl_out[g] = out_q;
    end

    // ------------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------------
    // mode and power outputs, one cycle behind their sources
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_enable <= 1'b0;
            link_sleep <= 1'b0;
            link_reduced_power <= 1'b0;
            repeater_mode <= 1'b0;
            legacy_format <= 1'b0;
            audio_b_mode <= 1'b0;
            color18_mode <= 1'b0;
        end else begin
            link_enable <= (state_d == SICP_ST_ACTIVE);
            link_sleep <= (state_d == SICP_ST_SLEEP);
            link_reduced_power <= (state_d == SICP_ST_REMOTE_PD);
            repeater_mode <= rep_eff;
            legacy_format <= bc_eff;
            audio_b_mode <= audb_eff;
            color18_mode <= c18_eff;
        end
    end

    assign link_active_flag = ctl_out[0];
    assign link_line_sync = ctl_out[1];
    assign link_frame_sync = ctl_out[2];

endmodule

`default_nettype wire

// ### test/sicp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sicp_host_model (
    // control from the bench
    input wire logic run,
    // parallel video pins
    output logic pclk,
    output logic [23:0] pix
);
    integer seed = 28;

    // 125 ns clock, still while run is low; data moves between edges
    initial begin
        pclk = 1'b0;
        pix = 24'h000000;
        forever begin
            #31.25;
            if (run) pclk = ~pclk;
            #31.25;
            pix = $random(seed);
        end
    end
endmodule

`default_nettype wire

// ### test/sicp_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "sicp_defs.svh"

module sicp_ctrl_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and link side
    input wire logic pclk_in,
    input wire logic powerdown_n,
    input wire logic remote_interrupt_in,
    input wire logic link_pixel_stb,
    input wire logic link_enable,
    input wire logic link_frame_sync,
    input wire logic interrupt_out_n
);
    wire logic acc = psel && penable && pready;
    wire logic isr_rd = acc && !pwrite && paddr[11:2] == `SICP_IDX_ISR;
    logic fwd_q;
    logic edge_q;
    logic [3:0] age_q;
    logic [12:0] fs_q;

    // mirrored control bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fwd_q <= 1'b0;
            edge_q <= 1'b1;
        end else if (acc && pwrite && !pslverr) begin
            if (paddr[11:2] == `SICP_IDX_INTCTL) fwd_q <= pwdata[5] & pwdata[0];
            if (paddr[11:2] == `SICP_IDX_CFG) edge_q <= pwdata[3];
        end
    end

    // saturating ages since remote fall and frame sync move
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            age_q <= 4'hf;
            fs_q <= 13'h1fff;
        end else begin
            age_q <= $fell(remote_interrupt_in) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
            fs_q <= $changed(link_frame_sync) ? 13'h0000 : fs_q + {12'h000, fs_q != 13'h1fff};
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("pready not one cycle after setup");
    property p_err;
        pslverr |-> pready && prdata == 32'h00000000;
    endproperty
    a_err: assert property (p_err)
        else $error("refused access without pready or with data");
    property p_pd;
        !powerdown_n [*6] |-> !link_enable && !link_pixel_stb;
    endproperty
    a_pd: assert property (p_pd)
        else $error("link alive in power-down");
    property p_stb;
        link_pixel_stb |-> link_enable;
    endproperty
    a_stb: assert property (p_stb)
        else $error("capture outside active state");
    property p_edge;
        link_pixel_stb |-> pclk_in == edge_q;
    endproperty
    a_edge: assert property (p_edge)
        else $error("capture on the wrong pixel clock edge");
    property p_clear;
        remote_interrupt_in [*6] ##0 isr_rd |=> interrupt_out_n;
    endproperty
    a_clear: assert property (p_clear)
        else $error("status read left interrupt pending");
    property p_fwd;
        $fell(remote_interrupt_in) && fwd_q |-> ##[1:6] !interrupt_out_n;
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("remote interrupt not forwarded");
    property p_cause;
        $fell(interrupt_out_n) |-> fwd_q && age_q < 4'h8;
    endproperty
    a_cause: assert property (p_cause)
        else $error("interrupt without a fresh remote edge");
    property p_fs;
        $changed(link_frame_sync) |-> fs_q > 13'h0fa0;
    endproperty
    a_fs: assert property (p_fs)
        else $error("frame sync moved twice within the window");
endmodule

`default_nettype wire

// ### test/test_sicp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sicp_defs.svh"

module test_sicp_ctrl;
    // stimulus, all valued at time zero
    logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic run = 1'b0, video_active_flag = 1'b0, line_sync = 1'b0, frame_sync = 1'b0;
    logic powerdown_n = 1'b1, link_detect = 1'b1, remote_powered_down = 1'b0;
    logic remote_interrupt_in = 1'b1;
    logic [3:0] config_strap_level = 4'h0;
    // observed
    logic [31:0] prdata, rd;
    logic [23:0] pixel_data_in, link_pixel_data;
    logic pready, pslverr, pclk_in, re, link_pixel_stb, link_active_flag, link_line_sync;
    logic link_frame_sync, link_enable, link_sleep, link_reduced_power, low_freq_range;
    logic repeater_mode, legacy_format, audio_b_mode, color18_mode, interrupt_out_n;
    logic [3:0] e;
    logic lad;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;

    sicp_ctrl DUT (.*, .secondary_audio_data(1'b1), .link_audio_data(lad));
    sicp_host_model host (.run, .pclk(pclk_in), .pix(pixel_data_in));

    // clock; a hang hits the ceiling
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total = err_total + 1;
            conclude();
        end
    end

    task automatic conclude();
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one transfer, idle edge first
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pdc();
        powerdown_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        powerdown_n <= 1'b1;
        repeat (20) @(posedge clk_sys);
    endtask

    task automatic wstb();
        @(posedge clk_sys);
        while (link_pixel_stb !== 1'b1) begin
            @(posedge clk_sys);
        end
    endtask

    // both flags high for n pixel periods; did they get out
    task automatic pulse(input int n, input logic x);
        logic s;
        s = 1'b0;
        line_sync <= 1'b1;
        video_active_flag <= 1'b1;
        for (int k = 0; k < 31 * n + 300; k++) begin
            @(posedge clk_sys);
            if (k == 31 * n) begin
                line_sync <= 1'b0;
                video_active_flag <= 1'b0;
            end
            s = s | (link_line_sync & link_active_flag);
        end
        chk({31'h0, s}, {31'h0, x});
        repeat (140) @(posedge pclk_in);
    endtask

    // strap index to {low freq, repeater, backward compatible, audio b}
    function automatic logic [3:0] strap_exp(input int i);
        logic [3:0] t [0:9];
        t = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc, 4'hd, 4'h2, 4'ha};
        return (i < 10) ? t[i] : 4'h0;
    endfunction

    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        run <= 1'b1;
        apb(0, `SICP_IDX_CFG, 8'h00);
        chk(rd, 32'h0000000c);
        apb(1, 10'h3ff, 8'h5a);
        chk({31'h0, re}, 32'h1);
        apb(0, 10'h3ff, 8'h00);
        chk({re, rd[30:0]}, 32'h80000000);
        link_detect <= 1'b0;
        repeat (4) @(posedge clk_sys);
        apb(0, `SICP_IDX_STAT, 8'h00);
        chk({31'h0, rd[0]}, 32'h0);
        link_detect <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            config_strap_level <= i[3:0];
            pdc();
            config_strap_level <= 4'hf;
            repeat (10) @(posedge clk_sys);
            e = strap_exp(i);
            chk({28'h0, low_freq_range, repeater_mode, legacy_format, audio_b_mode},
                {28'h0, e});
            chk({31'h0, color18_mode}, {31'h0, e[0]});
        end
        chk({31'h0, link_enable}, 32'h1);
        apb(1, `SICP_IDX_CFG, 8'h0d);
        repeat (10) @(posedge clk_sys);
        chk({31'h0, low_freq_range}, 32'h0);
        pdc();
        chk({31'h0, low_freq_range}, 32'h1);
        for (int m = 0; m < 4; m++) begin
            powerdown_n <= 1'b0;
            repeat (8) @(posedge clk_sys);
            apb(1, `SICP_IDX_CFG, m[0] ? 8'h0c : 8'h04);
            apb(1, `SICP_IDX_AUD, m[1] ? 8'h05 : 8'h00);
            powerdown_n <= 1'b1;
            repeat (20) @(posedge clk_sys);
            chk({30'h0, audio_b_mode, color18_mode}, {30'h0, m[1], m[1]});
            for (int k = 0; k < 6; k++) begin
                wstb();
                chk({7'h00, lad, link_pixel_data},
                    {7'h00, m[1], pixel_data_in & (m[1] ? `SICP_COLOR18_MASK : 24'hffffff)});
            end
        end
        pulse(1, 1'b0);
        pulse(6, 1'b1);
        apb(1, `SICP_IDX_CFG, 8'h08);
        pulse(2, 1'b1);
        frame_sync <= 1'b1;
        repeat (10) @(posedge pclk_in);
        @(posedge clk_sys);
        frame_sync <= 1'b0;
        chk({31'h0, link_frame_sync}, 32'h1);
        repeat (100) @(posedge pclk_in);
        chk({31'h0, link_frame_sync}, 32'h1);
        repeat (40) @(posedge pclk_in);
        chk({31'h0, link_frame_sync}, 32'h0);
        apb(1, `SICP_IDX_INTCTL, 8'h21);
        remote_interrupt_in <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk({31'h0, interrupt_out_n}, 32'h0);
        apb(0, `SICP_IDX_ISR, 8'h00);
        chk(rd, 32'h00000003);
        repeat (10) @(posedge clk_sys);
        chk({31'h0, interrupt_out_n}, 32'h1);
        remote_interrupt_in <= 1'b1;
        repeat (10) @(posedge clk_sys);
        remote_interrupt_in <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk({31'h0, interrupt_out_n}, 32'h0);
        remote_interrupt_in <= 1'b1;
        repeat (10) @(posedge clk_sys);
        apb(0, `SICP_IDX_ISR, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, interrupt_out_n}, 32'h1);
        apb(1, `SICP_IDX_PWR, 8'h80);
        remote_powered_down <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk({30'h0, link_reduced_power, link_enable}, 32'h2);
        remote_powered_down <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk({30'h0, link_reduced_power, link_enable}, 32'h1);
        apb(1, `SICP_IDX_PWR, 8'h40);
        run <= 1'b0;
        repeat (400) @(posedge clk_sys);
        chk({31'h0, link_sleep}, 32'h1);
        apb(0, `SICP_IDX_PWR, 8'h00);
        chk(rd, 32'h00000040);
        apb(0, `SICP_IDX_INTCTL, 8'h00);
        chk(rd, 32'h00000021);
        run <= 1'b1;
        repeat (200) @(posedge clk_sys);
        chk({30'h0, link_sleep, link_enable}, 32'h1);
        conclude();
    end
endmodule

bind sicp_ctrl sicp_ctrl_asserts chk_u (.*);

`default_nettype wire
